// *** hw/gsc_pkg.sv ***
// Purpose: types shared by the gauge control block
// Assumes: nothing beyond the register header
// Notes:   one-hot codes written out
package gsc_pkg;
  typedef enum logic [2:0] {
    GSC_RUN    = 3'b001,
    GSC_SAMPLE = 3'b010,
    GSC_SLEEP  = 3'b100
  } gsc_mode_e;
endpackage

// *** hw/gsc_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts for the gauge control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   all values held as macros
`ifndef GSC_REGS_SVH
`define GSC_REGS_SVH
`define GSC_OFF_CTRL        12'h000
`define GSC_OFF_SLEEP_LIM   12'h004
`define GSC_OFF_WAKE_CFG    12'h008
`define GSC_OFF_CHG_DET     12'h00C
`define GSC_OFF_PERIODS     12'h010
`define GSC_OFF_SAMPLE_CFG  12'h014
`define GSC_OFF_ERR_CFG     12'h018
`define GSC_OFF_EOD_VOLT    12'h01C
`define GSC_OFF_RELEARN_LIM 12'h020
`define GSC_OFF_STATUS      12'h024
`define GSC_OFF_CAPACITY    12'h028
`define GSC_OFF_ACC_ERR     12'h02C
`define GSC_OFF_FULL_CAP    12'h030
`define GSC_OFF_FCC         12'h034
`define GSC_OFF_SAMPLE_THR  12'h038
`define GSC_OFF_SELF_DIS    12'h03C
`define GSC_CTRL_GAUGE_EN   0
`define GSC_CTRL_SAMPLE     1
`define GSC_STAT_INC        0
`define GSC_STAT_SLEEP      1
`define GSC_STAT_FULL_EOC   2
`define GSC_STAT_PARTIAL    3
`define GSC_STAT_RT_ALARM   9
`define GSC_STAT_RC_ALARM   8
`define GSC_STAT_TERMINATE  11
`define GSC_WAKE_VOLT_EN    0
`define GSC_WAKE_CURR_EN    1
`define GSC_WAKE_BUS_EN     2
`define GSC_WAKE_PIN_EN     3
`define GSC_WAKE_LVL_LSB    4
`define GSC_WAKE_LVL_STEP_MV 16'd256
`define GSC_RST_CHG_DET     16'h0010
`define GSC_RST_STATE_CHG   8'h02
`define GSC_RST_EOD_CONF    8'h03
`define GSC_RST_OWN_DRAIN   16'h004D
`define GSC_RST_SLEEP_LIM   16'h1770
`define GSC_RST_CAL         16'h30D4
`define GSC_RST_SAMPLE_LIM  16'h001B
`define GSC_RST_FCC         32'h00001000
`define GSC_RST_WAKE_CFG    8'hFF
`define GSC_RST_RELEARN     16'hFFFF
`define GSC_SAMPLE_SHIFT    14
`define GSC_PERIOD_MS       500
`endif

// *** hw/gsc_top.sv ***
// Purpose: sleep control, charge direction and capacity accounting of a battery gauge
// Assumes: measurements arrive as plain inputs with a one-cycle period strobe
// Notes:   registers on APB; capacity saturates at zero, the error accumulator only grows until end of discharge
`include "gsc_regs.svh"
module gsc_top #(
  parameter int CNT_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        period_tick,
  input  wire logic [15:0] pack_voltage_input,
  input  wire logic [15:0] cell_voltage,
  input  wire logic signed [15:0] current_ma,
  input  wire logic [15:0] period_charge,
  input  wire logic [15:0] eod_threshold_mv,
  input  wire logic        bus_activity,
  input  wire logic        pin_activity,
  input  wire logic        full_charge_eoc,
  input  wire logic        time_alarm_req,
  input  wire logic        cap_alarm_req,
  output logic             sleep_active_ff,
  output logic             gauge_display_en_ff,
  output logic             capacity_increasing_state_ff,
  output logic             alarm_warning_ff
);
  if (CNT_W < 4 || CNT_W > 8) begin
    $error("gsc_top: CNT_W must be 4..8");
  end
  gsc_pkg::gsc_mode_e mode_ff;
  logic [15:0] sleep_pack_voltage_limit_ff;
  logic [7:0]  wake_source_config_ff;
  logic [15:0] charge_detect_current_ff;
  logic [7:0]  state_change_periods_ff;
  logic [7:0]  discharge_end_confirm_periods_ff;
  logic [15:0] sample_threshold_param_ff;
  logic [15:0] current_calibration_factor_ff;
  logic [15:0] current_error_term_ff;
  logic [15:0] self_discharge_error_term_ff;
  logic [15:0] own_drain_term_ff;
  logic [15:0] self_dis_pct_ff;
  logic [15:0] relearn_rate_limit_ff;
  logic [15:0] eod_volt_ff;
  logic [31:0] capacity_ff;
  logic [31:0] accumulated_error_ff;
  logic [31:0] learned_full_capacity_ff;
  logic [31:0] full_charge_capacity_ff;
  logic [31:0] capacity_at_full_ff;
  logic        gauge_en_ff;
  logic        full_eoc_ff;
  logic        partial_ff;
  logic        terminate_alarm_flag_ff;
  logic        rt_alarm_ff;
  logic        rc_alarm_ff;
  logic [CNT_W-1:0] dir_cnt_ff;
  logic [CNT_W-1:0] eod_cnt_ff;
  logic [CNT_W-1:0] mode_cnt_ff;
  logic [31:0] sample_thr;
  logic [15:0] abs_curr;
  logic        above_sample;
  logic        charge_seen;
  logic        wake_hit;
  logic [15:0] wake_level_mv;
  logic        gauging;
  logic        eod_valid;
  logic        apb_acc;
  logic [31:0] drain_term;
  logic [47:0] self_prod;
  logic [31:0] self_term;
  logic [31:0] loss;
  logic [31:0] err_step;
  logic [31:0] nxt_capacity;
  logic [CNT_W-1:0] dir_lim;
  logic [CNT_W-1:0] eod_lim;

  assign sample_thr = (32'(sample_threshold_param_ff) * 32'(current_calibration_factor_ff))
                      >> `GSC_SAMPLE_SHIFT;
  assign abs_curr = current_ma[15] ? 16'(-current_ma) : current_ma;
  assign above_sample = 32'(abs_curr) > sample_thr;
  assign charge_seen = !current_ma[15] && (current_ma > $signed(charge_detect_current_ff));
  assign wake_level_mv = 16'(wake_source_config_ff[7:`GSC_WAKE_LVL_LSB]) * `GSC_WAKE_LVL_STEP_MV;
  // wake decode uses no cell count input at all
  assign wake_hit = (wake_source_config_ff[`GSC_WAKE_VOLT_EN] &&
                     pack_voltage_input >= wake_level_mv) ||
                    (wake_source_config_ff[`GSC_WAKE_CURR_EN] && above_sample) ||
                    (wake_source_config_ff[`GSC_WAKE_BUS_EN] && bus_activity) ||
                    (wake_source_config_ff[`GSC_WAKE_PIN_EN] && pin_activity);
  assign gauging = gauge_en_ff && (mode_ff != gsc_pkg::GSC_SLEEP);
  assign dir_lim = CNT_W'(state_change_periods_ff);
  assign eod_lim = CNT_W'(discharge_end_confirm_periods_ff);
  assign eod_valid = gauging && period_tick && !capacity_increasing_state_ff &&
                     cell_voltage < eod_volt_ff && eod_cnt_ff + 1'b1 >= eod_lim;
  // own drain scaled: 77 counts per 300 uA per period, in capacity units
  assign drain_term = 32'(own_drain_term_ff);
  assign self_prod = 48'(self_dis_pct_ff) * 48'(full_charge_capacity_ff);
  assign self_term = self_prod[47:16];
  // all terms only ever reduce the estimate
  assign loss = 32'(current_error_term_ff) + drain_term + self_term +
                32'(self_discharge_error_term_ff);
  assign err_step = 32'(current_error_term_ff) + 32'(self_discharge_error_term_ff);
  always_comb begin
    nxt_capacity = capacity_ff;
    if (capacity_increasing_state_ff) begin
      nxt_capacity = capacity_ff + 32'(period_charge);
    end else if (capacity_ff > 32'(period_charge)) begin
      nxt_capacity = capacity_ff - 32'(period_charge);
    end else begin
      nxt_capacity = '0;
    end
    nxt_capacity = (nxt_capacity > loss) ? nxt_capacity - loss : '0;
  end

  // power mode sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= gsc_pkg::GSC_SAMPLE;
      mode_cnt_ff <= '0;
    end else begin
      case (mode_ff)
        gsc_pkg::GSC_RUN: begin
          if (period_tick) begin
            mode_cnt_ff <= above_sample ? '0 : mode_cnt_ff + 1'b1;
            if (!above_sample && mode_cnt_ff == CNT_W'(1)) begin
              mode_ff <= gsc_pkg::GSC_SAMPLE;
              mode_cnt_ff <= '0;
            end
          end
        end
        gsc_pkg::GSC_SAMPLE: begin
          if (period_tick) begin
            if (!above_sample && pack_voltage_input < sleep_pack_voltage_limit_ff) begin
              mode_ff <= gsc_pkg::GSC_SLEEP;
              mode_cnt_ff <= '0;
            end else if (above_sample && mode_cnt_ff == CNT_W'(1)) begin
              mode_ff <= gsc_pkg::GSC_RUN;
              mode_cnt_ff <= '0;
            end else begin
              mode_cnt_ff <= above_sample ? mode_cnt_ff + 1'b1 : '0;
            end
          end
        end
        gsc_pkg::GSC_SLEEP: begin
          if (wake_hit) begin
            mode_ff <= gsc_pkg::GSC_RUN;
          end
        end
        default: mode_ff <= gsc_pkg::GSC_SAMPLE;
      endcase
    end
  end

  // charge direction with persistence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capacity_increasing_state_ff <= 1'b0;
      dir_cnt_ff <= '0;
    end else if (gauging && period_tick) begin
      if (charge_seen == capacity_increasing_state_ff) begin
        dir_cnt_ff <= '0;
      end else if (dir_cnt_ff + 1'b1 >= dir_lim) begin
        capacity_increasing_state_ff <= charge_seen;
        dir_cnt_ff <= '0;
      end else begin
        dir_cnt_ff <= dir_cnt_ff + 1'b1;
      end
    end
  end

  // end-of-discharge confirmation and threshold tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eod_cnt_ff <= '0;
      eod_volt_ff <= '0;
    end else if (gauging && period_tick) begin
      eod_volt_ff <= eod_threshold_mv;
      if (capacity_increasing_state_ff || cell_voltage >= eod_volt_ff || eod_valid) begin
        eod_cnt_ff <= '0;
      end else begin
        eod_cnt_ff <= eod_cnt_ff + 1'b1;
      end
    end
  end

  // capacity, error, relearn and status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capacity_ff <= '0;
      accumulated_error_ff <= '0;
      learned_full_capacity_ff <= `GSC_RST_FCC;
      full_charge_capacity_ff <= `GSC_RST_FCC;
      capacity_at_full_ff <= '0;
      full_eoc_ff <= 1'b0;
      partial_ff <= 1'b0;
      terminate_alarm_flag_ff <= 1'b0;
      rt_alarm_ff <= 1'b0;
      rc_alarm_ff <= 1'b0;
    end else if (gauging && period_tick) begin
      capacity_ff <= nxt_capacity;
      accumulated_error_ff <= accumulated_error_ff + err_step;
      rt_alarm_ff <= time_alarm_req;
      rc_alarm_ff <= cap_alarm_req;
      if (full_charge_eoc) begin
        full_eoc_ff <= 1'b1;
        partial_ff <= 1'b0;
        capacity_at_full_ff <= nxt_capacity;
        terminate_alarm_flag_ff <= 1'b0;
      end else if (capacity_increasing_state_ff && !full_eoc_ff) begin
        partial_ff <= 1'b1;
      end else if (capacity_increasing_state_ff && full_eoc_ff && charge_seen) begin
        partial_ff <= 1'b1;
      end
      if (eod_valid) begin
        terminate_alarm_flag_ff <= 1'b1;
        accumulated_error_ff <= '0;
        if (full_eoc_ff && !partial_ff && abs_curr <= relearn_rate_limit_ff) begin
          learned_full_capacity_ff <= capacity_at_full_ff - nxt_capacity;
          full_charge_capacity_ff <= capacity_at_full_ff - nxt_capacity;
        end
        full_eoc_ff <= 1'b0;
        partial_ff <= 1'b0;
      end
    end
  end

  // outputs seen by the pack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_active_ff <= 1'b0;
      gauge_display_en_ff <= 1'b0;
      alarm_warning_ff <= 1'b0;
    end else begin
      sleep_active_ff <= (mode_ff == gsc_pkg::GSC_SLEEP);
      gauge_display_en_ff <= gauging;
      alarm_warning_ff <= terminate_alarm_flag_ff || rt_alarm_ff || rc_alarm_ff;
    end
  end

  // apb slave: zero wait, writes ignored while asleep
  assign apb_acc = psel && penable && (mode_ff != gsc_pkg::GSC_SLEEP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `GSC_OFF_CTRL:        prdata <= {30'h0, mode_ff == gsc_pkg::GSC_SAMPLE, gauge_en_ff};
          `GSC_OFF_SLEEP_LIM:   prdata <= {16'h0, sleep_pack_voltage_limit_ff};
          `GSC_OFF_WAKE_CFG:    prdata <= {24'h0, wake_source_config_ff};
          `GSC_OFF_CHG_DET:     prdata <= {16'h0, charge_detect_current_ff};
          `GSC_OFF_PERIODS:     prdata <= {16'h0, discharge_end_confirm_periods_ff,
                                           state_change_periods_ff};
          `GSC_OFF_SAMPLE_CFG:  prdata <= {current_calibration_factor_ff,
                                           sample_threshold_param_ff};
          `GSC_OFF_ERR_CFG:     prdata <= {self_discharge_error_term_ff, current_error_term_ff};
          `GSC_OFF_EOD_VOLT:    prdata <= {16'h0, own_drain_term_ff};
          `GSC_OFF_RELEARN_LIM: prdata <= {16'h0, relearn_rate_limit_ff};
          `GSC_OFF_STATUS:      prdata <= {20'h0, terminate_alarm_flag_ff, 1'b0, rt_alarm_ff,
                                           rc_alarm_ff, 4'h0, partial_ff, full_eoc_ff,
                                           mode_ff == gsc_pkg::GSC_SLEEP,
                                           capacity_increasing_state_ff};
          `GSC_OFF_CAPACITY:    prdata <= capacity_ff;
          `GSC_OFF_ACC_ERR:     prdata <= accumulated_error_ff;
          `GSC_OFF_FULL_CAP:    prdata <= learned_full_capacity_ff;
          `GSC_OFF_FCC:         prdata <= full_charge_capacity_ff;
          `GSC_OFF_SAMPLE_THR:  prdata <= sample_thr;
          `GSC_OFF_SELF_DIS:    prdata <= {16'h0, self_dis_pct_ff};
          default: begin
            prdata <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gauge_en_ff <= 1'b1;
      sleep_pack_voltage_limit_ff <= `GSC_RST_SLEEP_LIM;
      wake_source_config_ff <= `GSC_RST_WAKE_CFG;
      charge_detect_current_ff <= `GSC_RST_CHG_DET;
      state_change_periods_ff <= `GSC_RST_STATE_CHG;
      discharge_end_confirm_periods_ff <= `GSC_RST_EOD_CONF;
      sample_threshold_param_ff <= `GSC_RST_SAMPLE_LIM;
      current_calibration_factor_ff <= `GSC_RST_CAL;
      current_error_term_ff <= '0;
      self_discharge_error_term_ff <= '0;
      own_drain_term_ff <= `GSC_RST_OWN_DRAIN;
      relearn_rate_limit_ff <= `GSC_RST_RELEARN;
      self_dis_pct_ff <= '0;
    end else if (apb_acc && pwrite && pready) begin
      case (paddr)
        `GSC_OFF_CTRL:        gauge_en_ff <= pwdata[`GSC_CTRL_GAUGE_EN];
        `GSC_OFF_SLEEP_LIM:   sleep_pack_voltage_limit_ff <= pwdata[15:0];
        `GSC_OFF_WAKE_CFG:    wake_source_config_ff <= pwdata[7:0];
        `GSC_OFF_CHG_DET:     charge_detect_current_ff <= pwdata[15:0];
        `GSC_OFF_PERIODS: begin
          state_change_periods_ff <= pwdata[7:0];
          discharge_end_confirm_periods_ff <= pwdata[15:8];
        end
        `GSC_OFF_SAMPLE_CFG: begin
          sample_threshold_param_ff <= pwdata[15:0];
          current_calibration_factor_ff <= pwdata[31:16];
        end
        `GSC_OFF_ERR_CFG: begin
          current_error_term_ff <= pwdata[15:0];
          self_discharge_error_term_ff <= pwdata[31:16];
        end
        `GSC_OFF_EOD_VOLT:    own_drain_term_ff <= pwdata[15:0];
        `GSC_OFF_RELEARN_LIM: relearn_rate_limit_ff <= pwdata[15:0];
        `GSC_OFF_SELF_DIS:    self_dis_pct_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == gsc_pkg::GSC_SAMPLE && period_tick && above_sample) |=>
      mode_ff != gsc_pkg::GSC_SLEEP)
    else $error("sleep entered with high current");
  sleep_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == gsc_pkg::GSC_SLEEP && !wake_hit) |=> mode_ff == gsc_pkg::GSC_SLEEP)
    else $error("sleep left without wake");
  sleep_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == gsc_pkg::GSC_RUN) |=> mode_ff != gsc_pkg::GSC_SLEEP)
    else $error("sleep entered from run");
  sleep_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == gsc_pkg::GSC_SLEEP) |=> $stable(accumulated_error_ff))
    else $error("gauging while asleep");
  eod_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    eod_valid |=> terminate_alarm_flag_ff && accumulated_error_ff == 32'h0)
    else $error("end of discharge not flagged");
  cap_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gauging && period_tick && !capacity_increasing_state_ff && !eod_valid) |=>
      capacity_ff <= $past(capacity_ff))
    else $error("capacity rose while decreasing");
  dir_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dir_cnt_ff == '0 && dir_lim > CNT_W'(1) && gauging && period_tick) |=>
      $stable(capacity_increasing_state_ff))
    else $error("direction changed too soon");
  err_grow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gauging && period_tick && !eod_valid) |=>
      accumulated_error_ff == $past(accumulated_error_ff) + $past(err_step))
    else $error("error not accumulated");
  sleep_cov: cover property (@(posedge pclk) mode_ff == gsc_pkg::GSC_SLEEP ##1
    mode_ff == gsc_pkg::GSC_RUN);
  eod_cov: cover property (@(posedge pclk) eod_valid);
  dir_cov: cover property (@(posedge pclk) $rose(capacity_increasing_state_ff));
endmodule

// *** verif/gsc_meas_src.sv ***
// Purpose: time base model that strobes one measurement period
// Assumes: the strobe is one clock wide and comes every GAP cycles
// Notes:   holds still while reset is low
module gsc_meas_src #(
  parameter int GAP = 20
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      period_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff      <= 0;
      period_tick <= 1'b0;
    end else begin
      cnt_ff      <= (cnt_ff == GAP - 1) ? 0 : cnt_ff + 1;
      period_tick <= (cnt_ff == GAP - 1);
    end
  end
endmodule

// *** verif/tb_gauge_sleep_and_capacity_control.sv ***
// Purpose: self-checking bench for the gauge control block
// Assumes: zero-wait APB slave, one-cycle period strobe from the time base model
// Notes:   register rows first, then direction, end of discharge, sleep, reset and capacity cases
`include "gsc_regs.svh"
module tb_gauge_sleep_and_capacity_control;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic        err;
  } gsc_row_s;
  localparam logic [31:0] SAMPLE_THR = (32'(`GSC_RST_SAMPLE_LIM) * 32'(`GSC_RST_CAL)) >> 14;
  localparam logic [15:0] PCHG       = 16'h0010;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               period_tick;
  logic [15:0]        pack_voltage_input;
  logic [15:0]        cell_voltage;
  logic signed [15:0] current_ma;
  logic [15:0]        period_charge;
  logic [15:0]        eod_threshold_mv;
  logic               bus_activity;
  logic               full_charge_eoc;
  logic               cap_alarm_req;
  logic               sleep_active_ff;
  logic               gauge_display_en_ff;
  logic               capacity_increasing_state_ff;
  logic               alarm_warning_ff;
  logic [31:0]        rd;
  logic               er;
  int                 n_mismatch;
  int                 cmp_count;
  gsc_row_s           rows [11] = '{
    '{1'b0, `GSC_OFF_CHG_DET, 32'(`GSC_RST_CHG_DET), 1'b0},
    '{1'b0, `GSC_OFF_PERIODS, {16'h0000, `GSC_RST_EOD_CONF, `GSC_RST_STATE_CHG}, 1'b0},
    '{1'b0, `GSC_OFF_SAMPLE_CFG, {`GSC_RST_CAL, `GSC_RST_SAMPLE_LIM}, 1'b0},
    '{1'b0, `GSC_OFF_EOD_VOLT, 32'(`GSC_RST_OWN_DRAIN), 1'b0},
    '{1'b0, `GSC_OFF_SLEEP_LIM, 32'(`GSC_RST_SLEEP_LIM), 1'b0},
    '{1'b0, `GSC_OFF_FCC, `GSC_RST_FCC, 1'b0},
    '{1'b0, `GSC_OFF_SAMPLE_THR, SAMPLE_THR, 1'b0},
    '{1'b0, 12'h040, 32'h0000_0000, 1'b1},
    '{1'b1, `GSC_OFF_WAKE_CFG, 32'h0000_0004, 1'b0},
    '{1'b0, `GSC_OFF_WAKE_CFG, 32'h0000_0004, 1'b0},
    '{1'b1, `GSC_OFF_ERR_CFG, 32'h0002_0003, 1'b0}
  };

  gsc_meas_src #(.GAP(20)) tbase (.pclk(pclk), .presetn(presetn), .period_tick(period_tick));

  gsc_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .period_tick(period_tick), .pack_voltage_input(pack_voltage_input),
    .cell_voltage(cell_voltage), .current_ma(current_ma), .period_charge(period_charge),
    .eod_threshold_mv(eod_threshold_mv), .bus_activity(bus_activity), .pin_activity(1'b0),
    .full_charge_eoc(full_charge_eoc), .time_alarm_req(1'b0), .cap_alarm_req(cap_alarm_req),
    .sleep_active_ff(sleep_active_ff), .gauge_display_en_ff(gauge_display_en_ff),
    .capacity_increasing_state_ff(capacity_increasing_state_ff),
    .alarm_warning_ff(alarm_warning_ff)
  );

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin
        n_mismatch++;
        complete_run();
      end
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait n strobes; outputs read two edges later are settled
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk iff period_tick);
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, bus_activity} = 4'h0;
    {full_charge_eoc, cap_alarm_req} = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pack_voltage_input = 16'h3000;
    cell_voltage = 16'h1000;
    current_ma = 16'sh0000;
    period_charge = PCHG;
    eod_threshold_mv = 16'h0BB8;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data, rd, er);
      if (!rows[i].wr) begin
        chk(rd, rows[i].data, "register");
        chk({31'b0, er}, {31'b0, rows[i].err}, "slave error");
      end
    end
    $display("test registers done");
    @(posedge pclk);
    current_ma <= 16'sd100;
    ticks(1);
    chk({31'b0, capacity_increasing_state_ff}, 32'h0, "early change");
    ticks(1);
    chk({31'b0, capacity_increasing_state_ff}, 32'h1, "increasing");
    current_ma <= -16'sd50;
    ticks(1);
    current_ma <= 16'sd100;
    ticks(1);
    current_ma <= -16'sd50;
    ticks(1);
    chk({31'b0, capacity_increasing_state_ff}, 32'h1, "count restart");
    ticks(1);
    chk({31'b0, capacity_increasing_state_ff}, 32'h0, "decreasing");
    $display("test direction done");
    cell_voltage <= 16'h0B54;
    ticks(2);
    apb(1'b0, `GSC_OFF_STATUS, 32'h0, rd, er);
    chk({31'b0, rd[11]}, 32'h0, "terminate early");
    apb(1'b0, `GSC_OFF_ACC_ERR, 32'h0, rd, er);
    chk({31'b0, rd != 32'h0}, 32'h1, "error grows");
    ticks(1);
    apb(1'b0, `GSC_OFF_STATUS, 32'h0, rd, er);
    chk({31'b0, rd[11]}, 32'h1, "terminate");
    chk({31'b0, alarm_warning_ff}, 32'h1, "alarm");
    apb(1'b0, `GSC_OFF_ACC_ERR, 32'h0, rd, er);
    chk(rd, 32'h0, "error cleared");
    apb(1'b0, `GSC_OFF_FCC, 32'h0, rd, er);
    chk(rd, `GSC_RST_FCC, "no relearn after partial");
    $display("test end of discharge done");
    pack_voltage_input <= 16'h1000;
    ticks(2);
    chk({31'b0, sleep_active_ff}, 32'h0, "no sleep in run");
    current_ma <= 16'sd0;
    ticks(4);
    chk({31'b0, sleep_active_ff}, 32'h1, "sleep");
    chk({31'b0, gauge_display_en_ff}, 32'h0, "display off");
    apb(1'b1, `GSC_OFF_SLEEP_LIM, 32'h0000_2000, rd, er);
    apb(1'b0, `GSC_OFF_SLEEP_LIM, 32'h0, rd, er);
    chk(rd, 32'(`GSC_RST_SLEEP_LIM), "write ignored");
    @(posedge pclk);
    bus_activity <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'b0, sleep_active_ff}, 32'h0, "wake");
    bus_activity <= 1'b0;
    $display("test sleep done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({27'b0, sleep_active_ff, gauge_display_en_ff, capacity_increasing_state_ff,
         alarm_warning_ff, pready}, 32'h0, "in reset");
    presetn <= 1'b1;
    pack_voltage_input <= 16'h3000;
    cell_voltage <= 16'h1000;
    repeat (2) @(posedge pclk);
    chk({31'b0, gauge_display_en_ff}, 32'h1, "display after reset");
    $display("test reset done");
    // no drain or error terms: capacity moves by the period charge alone
    current_ma <= 16'sd100;
    apb(1'b1, `GSC_OFF_EOD_VOLT, 32'h0, rd, er);
    ticks(3);
    apb(1'b0, `GSC_OFF_CAPACITY, 32'h0, rd, er);
    chk(rd, 32'(PCHG), "capacity up");
    full_charge_eoc <= 1'b1;
    cap_alarm_req <= 1'b1;
    current_ma <= 16'sd0;
    ticks(1);
    chk({31'b0, alarm_warning_ff}, 32'h1, "early alarm");
    full_charge_eoc <= 1'b0;
    cap_alarm_req <= 1'b0;
    ticks(1);
    apb(1'b1, `GSC_OFF_EOD_VOLT, 32'h5, rd, er);
    apb(1'b1, `GSC_OFF_ERR_CFG, 32'h0002_0003, rd, er);
    cell_voltage <= 16'h0B54;
    ticks(1);
    apb(1'b0, `GSC_OFF_CAPACITY, 32'h0, rd, er);
    chk(rd, (32'(PCHG) * 32'h3) - 32'(PCHG) - 32'h3 - 32'h5 - 32'h2, "terms");
    ticks(2);
    apb(1'b0, `GSC_OFF_FULL_CAP, 32'h0, rd, er);
    chk(rd, 32'(PCHG) * 32'h2, "relearn");
    apb(1'b0, `GSC_OFF_FCC, 32'h0, rd, er);
    chk(rd, 32'(PCHG) * 32'h2, "fcc relearn");
    $display("test capacity done");
    complete_run();
  end
endmodule
